// file: core/byte_alu_pkg.sv
// Purpose: Shared types and constants for the byte ALU datapath
// Assumes: Single core clock, decoder drives one operation per cycle
// Notes: Reset values and flag positions live here
`default_nettype none
package byte_alu_pkg;
    typedef enum logic [2:0] {
        OP_NONE,
        OP_LITERAL_MINUS_ACC,
        OP_ACC_XOR_LITERAL,
        OP_FILE_MINUS_ACC,
        OP_ACC_XOR_FILE,
        OP_FILE_NIBBLE_EXCHANGE
    } alu_op_t;

    typedef struct packed {
        logic carry;
        logic half_carry_flag;
        logic zero;
    } flags_t;

    typedef struct packed {
        alu_op_t op;
        logic [7:0] literal;
        logic [6:0] file_addr;
        logic dest_file;
        logic [7:0] file_data;
    } alu_req_t;

    typedef struct packed {
        logic file_we;
        logic [6:0] file_addr;
        logic [7:0] file_data;
    } file_wr_t;

    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [6:0] ADDR_RESET = 7'h00;
    localparam int FLAG_CARRY_POS = 2;
    localparam int FLAG_HALF_POS = 1;
    localparam int FLAG_ZERO_POS = 0;
    localparam logic [2:0] FLAGS_RESET = 3'h0;
    localparam int RESULT_LATENCY = 1;
endpackage
`default_nettype wire

// file: core/byte_alu_calc.sv
// Purpose: Combinational result and flag computation
// Assumes: Operands already selected by the caller
// Notes: Subtraction by adding the two's complement
`default_nettype none
module byte_alu_calc (
    input wire byte_alu_pkg::alu_op_t op_i,
    input wire logic [7:0] src_i,
    input wire logic [7:0] acc_i,
    output logic [7:0] result_o,
    output logic carry_o,
    output logic half_o,
    output logic zero_o,
    output logic flags_hit_o,
    output logic zero_hit_o
);
    wire logic [8:0] diff;
    wire logic [4:0] low_diff;
    wire logic is_sub;
    wire logic is_xor;
    wire logic is_swap;

    assign is_sub = (op_i == byte_alu_pkg::OP_LITERAL_MINUS_ACC) ||
                    (op_i == byte_alu_pkg::OP_FILE_MINUS_ACC);
    assign is_xor = (op_i == byte_alu_pkg::OP_ACC_XOR_LITERAL) ||
                    (op_i == byte_alu_pkg::OP_ACC_XOR_FILE);
    assign is_swap = (op_i == byte_alu_pkg::OP_FILE_NIBBLE_EXCHANGE);
    // Source plus inverted accumulator plus one
    assign diff = {1'b0, src_i} + {1'b0, ~acc_i} + 9'h001; // RULE1 RULE3
    assign low_diff = {1'b0, src_i[3:0]} + {1'b0, ~acc_i[3:0]} + 5'h01; // RULE1 RULE3
    assign result_o = is_sub ? diff[7:0] :
                      is_xor ? (src_i ^ acc_i) : // RULE2 RULE5
                      is_swap ? {src_i[3:0], src_i[7:4]} : // RULE6
                      8'h00;
    assign carry_o = diff[8];
    assign half_o = low_diff[4];
    assign zero_o = (result_o == 8'h00); // RULE8
    assign flags_hit_o = is_sub;
    assign zero_hit_o = is_sub || is_xor; // RULE2 RULE5 RULE6
endmodule
`default_nettype wire

// file: core/byte_alu_sub_xor_swap.sv
// Purpose: Byte ALU for subtract, exclusive OR and nibble exchange
// Assumes: Decoder presents one request per cycle on the core clock
// Notes: Results and flags appear one cycle after the request
// Notes on behaviour
// RULE1 - Literal minus accumulator into accumulator, updating carry, half carry and zero.
// RULE2 - Accumulator XOR literal into accumulator, only zero flag changes.
// RULE3 - File register minus accumulator, updating carry, half carry and zero.
// RULE4 - File subtract and XOR go to accumulator on select 0, file on 1.
// RULE5 - Accumulator XOR file register, only the zero flag changes.
// RULE6 - Nibble exchange swaps halves of the file byte, flags untouched.
// RULE7 - Swapped byte goes to accumulator on select 0, file on 1.
// RULE8 - Zero flag set when affected result is zero, else cleared.
`default_nettype none
module byte_alu_sub_xor_swap (
    input wire logic CLK_SYS_I,
    input wire logic ARST_N_I,
    input wire byte_alu_pkg::alu_req_t REQ_I,
    output logic [7:0] ACC_O,
    output var byte_alu_pkg::flags_t FLAGS_O,
    output var byte_alu_pkg::file_wr_t FILE_WR_O
);
    ////////////////////////////////////////////////////////////////////////
    // Operand selection
    logic [7:0] acc_r;
    logic [7:0] acc_nxt;
    byte_alu_pkg::flags_t flags_r;
    byte_alu_pkg::flags_t flags_nxt;
    byte_alu_pkg::file_wr_t wr_r;
    byte_alu_pkg::file_wr_t wr_nxt;
    wire logic [7:0] src;
    wire logic [7:0] result;
    wire logic carry;
    wire logic half;
    wire logic zero;
    wire logic flags_hit;
    wire logic zero_hit;
    wire logic is_file_op;
    wire logic to_file;

    function automatic logic op_uses_literal(input byte_alu_pkg::alu_op_t op);
        op_uses_literal = (op == byte_alu_pkg::OP_LITERAL_MINUS_ACC) ||
                          (op == byte_alu_pkg::OP_ACC_XOR_LITERAL);
    endfunction

    assign is_file_op = (REQ_I.op == byte_alu_pkg::OP_FILE_MINUS_ACC) ||
                        (REQ_I.op == byte_alu_pkg::OP_ACC_XOR_FILE) ||
                        (REQ_I.op == byte_alu_pkg::OP_FILE_NIBBLE_EXCHANGE);
    assign src = op_uses_literal(REQ_I.op) ? REQ_I.literal : REQ_I.file_data;
    assign to_file = is_file_op && REQ_I.dest_file; // RULE4 RULE7

    byte_alu_calc u_calc (
        .op_i(REQ_I.op),
        .src_i(src),
        .acc_i(acc_r),
        .result_o(result),
        .carry_o(carry),
        .half_o(half),
        .zero_o(zero),
        .flags_hit_o(flags_hit),
        .zero_hit_o(zero_hit)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state
    assign acc_nxt = (REQ_I.op != byte_alu_pkg::OP_NONE && !to_file) ? // RULE4 RULE7
                     result : acc_r;
    assign flags_nxt = {flags_hit ? carry : flags_r.carry, // RULE1 RULE3
                        flags_hit ? half : flags_r.half_carry_flag, // RULE1 RULE3
                        zero_hit ? zero : flags_r.zero}; // RULE8
    assign wr_nxt = {to_file, // RULE4 RULE7
                     to_file ? REQ_I.file_addr : byte_alu_pkg::ADDR_RESET,
                     to_file ? result : 8'h00};

    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            acc_r <= byte_alu_pkg::ACC_RESET;
            flags_r <= byte_alu_pkg::FLAGS_RESET;
            wr_r <= '0;
        end else begin
            acc_r <= acc_nxt;
            flags_r <= flags_nxt;
            wr_r <= wr_nxt;
        end
    end

    assign ACC_O = acc_r;
    assign FLAGS_O = flags_r;
    assign FILE_WR_O = wr_r;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_lit_sub;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        REQ_I.op == byte_alu_pkg::OP_LITERAL_MINUS_ACC |=>
            ACC_O == 8'($past(REQ_I.literal) - $past(acc_r)) && !FILE_WR_O.file_we;
    endproperty
    a_lit_sub: assert property (p_lit_sub) else $error("Literal subtract wrong"); // RULE1

    property p_lit_xor;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        REQ_I.op == byte_alu_pkg::OP_ACC_XOR_LITERAL |=>
            ACC_O == ($past(REQ_I.literal) ^ $past(acc_r)) &&
            FLAGS_O.carry == $past(flags_r.carry) &&
            FLAGS_O.half_carry_flag == $past(flags_r.half_carry_flag);
    endproperty
    a_lit_xor: assert property (p_lit_xor) else $error("Literal XOR wrong"); // RULE2

    property p_file_sub;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        REQ_I.op == byte_alu_pkg::OP_FILE_MINUS_ACC |=>
            FLAGS_O.carry == ($past(REQ_I.file_data) >= $past(acc_r)) &&
            FLAGS_O.half_carry_flag == ($past(REQ_I.file_data[3:0]) >= $past(acc_r[3:0]));
    endproperty
    a_file_sub: assert property (p_file_sub) else $error("File subtract flags wrong"); // RULE3

    property p_dest_file;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        (REQ_I.op == byte_alu_pkg::OP_FILE_MINUS_ACC ||
         REQ_I.op == byte_alu_pkg::OP_ACC_XOR_FILE) && REQ_I.dest_file |=>
            FILE_WR_O.file_we && FILE_WR_O.file_addr == $past(REQ_I.file_addr) &&
            ACC_O == $past(acc_r);
    endproperty
    a_dest_file: assert property (p_dest_file) else $error("File destination wrong"); // RULE4

    property p_file_xor;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        REQ_I.op == byte_alu_pkg::OP_ACC_XOR_FILE && !REQ_I.dest_file |=>
            ACC_O == ($past(REQ_I.file_data) ^ $past(acc_r)) &&
            FLAGS_O.carry == $past(flags_r.carry);
    endproperty
    a_file_xor: assert property (p_file_xor) else $error("File XOR wrong"); // RULE5

    property p_swap;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        REQ_I.op == byte_alu_pkg::OP_FILE_NIBBLE_EXCHANGE |=>
            FLAGS_O == $past(flags_r);
    endproperty
    a_swap: assert property (p_swap) else $error("Swap changed flags"); // RULE6

    property p_swap_dest;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        REQ_I.op == byte_alu_pkg::OP_FILE_NIBBLE_EXCHANGE && REQ_I.dest_file |=>
            FILE_WR_O.file_we &&
            FILE_WR_O.file_data == {$past(REQ_I.file_data[3:0]), $past(REQ_I.file_data[7:4])};
    endproperty
    a_swap_dest: assert property (p_swap_dest) else $error("Swap write wrong"); // RULE7

    property p_zero;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        zero_hit && !to_file |=> FLAGS_O.zero == (ACC_O == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("Zero flag wrong"); // RULE8

    property p_lit_flags;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        REQ_I.op == byte_alu_pkg::OP_LITERAL_MINUS_ACC |=>
            FLAGS_O.carry == ($past(REQ_I.literal) >= $past(acc_r)) &&
            FLAGS_O.half_carry_flag == ($past(REQ_I.literal[3:0]) >= $past(acc_r[3:0])) &&
            FLAGS_O.zero == (ACC_O == 8'h00);
    endproperty
    a_lit_flags: assert property (p_lit_flags) else $error("Sub flags wrong"); // RULE1

    property p_lit_dest;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        op_uses_literal(REQ_I.op) |=>
            !FILE_WR_O.file_we;
    endproperty
    a_lit_dest: assert property (p_lit_dest) else $error("Literal op wrote file"); // RULE1 RULE2

    property p_fsub_acc;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        REQ_I.op == byte_alu_pkg::OP_FILE_MINUS_ACC && !REQ_I.dest_file |=>
            ACC_O == 8'($past(REQ_I.file_data) - $past(acc_r)) &&
            !FILE_WR_O.file_we;
    endproperty
    a_fsub_acc: assert property (p_fsub_acc) else $error("Subtract to acc wrong"); // RULE3 RULE4

    property p_fsub_wr;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        REQ_I.op == byte_alu_pkg::OP_FILE_MINUS_ACC && REQ_I.dest_file |=>
            FILE_WR_O.file_data == 8'($past(REQ_I.file_data) - $past(acc_r));
    endproperty
    a_fsub_wr: assert property (p_fsub_wr) else $error("Subtract to file wrong"); // RULE4

    property p_xor_wr;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        REQ_I.op == byte_alu_pkg::OP_ACC_XOR_FILE && REQ_I.dest_file |=>
            FILE_WR_O.file_data == ($past(REQ_I.file_data) ^ $past(acc_r)) &&
            FLAGS_O.carry == $past(flags_r.carry) &&
            FLAGS_O.half_carry_flag == $past(flags_r.half_carry_flag);
    endproperty
    a_xor_wr: assert property (p_xor_wr) else $error("XOR to file wrong"); // RULE5

    property p_swap_acc;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        REQ_I.op == byte_alu_pkg::OP_FILE_NIBBLE_EXCHANGE && !REQ_I.dest_file |=>
            ACC_O == {$past(REQ_I.file_data[3:0]), $past(REQ_I.file_data[7:4])} &&
            !FILE_WR_O.file_we;
    endproperty
    a_swap_acc: assert property (p_swap_acc) else $error("Swap to acc wrong"); // RULE7

    property p_swap_addr;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        REQ_I.op == byte_alu_pkg::OP_FILE_NIBBLE_EXCHANGE && REQ_I.dest_file |=>
            FILE_WR_O.file_addr == $past(REQ_I.file_addr) &&
            ACC_O == $past(acc_r);
    endproperty
    a_swap_addr: assert property (p_swap_addr) else $error("Swap address wrong"); // RULE7

    property p_zero_file;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        zero_hit && to_file |=>
            FLAGS_O.zero == (FILE_WR_O.file_data == 8'h00);
    endproperty
    a_zero_file: assert property (p_zero_file) else $error("File zero flag wrong"); // RULE8

    property p_we_pulse;
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        !to_file |=>
            !FILE_WR_O.file_we;
    endproperty
    a_we_pulse: assert property (p_we_pulse) else $error("Stray file write"); // RULE4 RULE7
endmodule
`default_nettype wire

// file: verif/byte_alu_regfile_model.sv
// Purpose: Register file model feeding file operands to the byte ALU
// Assumes: Writes reported by the ALU land on the following edge
// Notes: Write-through, so a back-to-back read sees a pending write
`default_nettype none
module byte_alu_regfile_model (
    input wire logic clk_i,
    input wire logic [6:0] addr_i,
    input wire byte_alu_pkg::file_wr_t wr_i,
    output logic [7:0] data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [128];
    initial begin
        for (int a = 0; a < 128; a++) begin
            mem[a] = {a[6:0], 1'b1} ^ 8'ha5;
        end
    end
    always @(posedge clk_i) begin
        if (wr_i.file_we) begin
            mem[wr_i.file_addr] <= wr_i.file_data;
        end
    end
    assign data_o = (wr_i.file_we && wr_i.file_addr == addr_i) ? wr_i.file_data : mem[addr_i];
endmodule
`default_nettype wire

// file: verif/testbench.sv
// Purpose: Self-checking bench for the byte ALU
// Assumes: One request per cycle, results one cycle later
// Notes: Register file mirrored here to predict results
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, arst_n = 0, issued = 0, taken = 0, dest = 0;
    byte_alu_pkg::alu_op_t op = byte_alu_pkg::OP_NONE;
    logic [7:0] lit = 0, fdat, acc, acc_o, shadow [128];
    logic [6:0] addr = 0;
    byte_alu_pkg::flags_t flg, flags_o;
    byte_alu_pkg::file_wr_t wr_o;
    logic [7:0] q_acc [$];
    byte_alu_pkg::flags_t q_flg [$];
    byte_alu_pkg::file_wr_t q_wr [$];
    int mismatches = 0, num_checks = 0, cycles = 0;
    byte_alu_sub_xor_swap uut (.CLK_SYS_I(clk_sys), .ARST_N_I(arst_n),
        .REQ_I({op, lit, addr, dest, fdat}), .ACC_O(acc_o), .FLAGS_O(flags_o), .FILE_WR_O(wr_o));
    byte_alu_regfile_model model (.clk_i(clk_sys), .addr_i(addr), .wr_i(wr_o), .data_o(fdat));
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic compare(string n, logic [15:0] e, logic [15:0] s);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic chk_acc(logic [7:0] e);
        compare("acc", 16'(e), 16'(acc_o));
    endtask
    task automatic chk_flags(byte_alu_pkg::flags_t e);
        compare("flags", 16'(e), 16'(flags_o));
    endtask
    task automatic chk_wr(byte_alu_pkg::file_wr_t e);
        compare("file_wr", 16'(e), 16'(wr_o));
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic send(byte_alu_pkg::alu_op_t o, logic [7:0] l, logic [6:0] a, logic d);
        logic sub, xr, fop;
        logic [7:0] s, r;
        byte_alu_pkg::file_wr_t wr;
        sub = o == byte_alu_pkg::OP_LITERAL_MINUS_ACC || o == byte_alu_pkg::OP_FILE_MINUS_ACC;
        xr = o == byte_alu_pkg::OP_ACC_XOR_LITERAL || o == byte_alu_pkg::OP_ACC_XOR_FILE;
        fop = o == byte_alu_pkg::OP_FILE_MINUS_ACC || o == byte_alu_pkg::OP_ACC_XOR_FILE
            || o == byte_alu_pkg::OP_FILE_NIBBLE_EXCHANGE;
        s = fop ? shadow[a] : l;
        r = sub ? s - acc : xr ? s ^ acc : {s[3:0], s[7:4]};
        wr = '0;
        if (sub) begin
            flg.carry = s >= acc;
            flg.half_carry_flag = s[3:0] >= acc[3:0];
        end
        if (sub || xr) begin
            flg.zero = r == 8'h00;
        end
        if (o != byte_alu_pkg::OP_NONE && fop && d) begin
            wr = '{1'b1, a, r};
            shadow[a] = r;
        end else if (o != byte_alu_pkg::OP_NONE) begin
            acc = r;
        end
        q_acc.push_back(acc);
        q_flg.push_back(flg);
        q_wr.push_back(wr);
        op <= o;
        lit <= l;
        addr <= a;
        dest <= d;
        issued <= 1'b1;
        @(posedge clk_sys);
    endtask
    always @(posedge clk_sys) begin
        taken <= issued && arst_n;
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            end_of_test();
        end
    end
    always @(negedge clk_sys) begin
        if (taken && q_acc.size() > 0) begin
            chk_acc(q_acc.pop_front());
            chk_flags(q_flg.pop_front());
            chk_wr(q_wr.pop_front());
        end
    end
    initial begin
        acc = byte_alu_pkg::ACC_RESET;
        flg = byte_alu_pkg::FLAGS_RESET;
        for (int a = 0; a < 128; a++) begin
            shadow[a] = {a[6:0], 1'b1} ^ 8'ha5;
        end
        void'($urandom(32'h2ee6_bf97));
        repeat (16) @(posedge clk_sys);
        chk_acc(byte_alu_pkg::ACC_RESET);
        chk_flags(byte_alu_pkg::FLAGS_RESET);
        chk_wr('0);
        $display("test reset done");
        arst_n <= 1'b1;
        @(posedge clk_sys);
        for (int o = 0; o < 6; o++) begin
            for (int k = 0; k < 4; k++) begin
                send(byte_alu_pkg::alu_op_t'(o), k[0] ? 8'hff : 8'h00, k[0] ? 7'h7f : 7'h00, k[1]);
            end
        end
        send(byte_alu_pkg::OP_LITERAL_MINUS_ACC, acc, 7'h00, 1'b0);
        send(byte_alu_pkg::OP_ACC_XOR_LITERAL, acc, 7'h00, 1'b0);
        $display("test boundaries done");
        for (int i = 0; i < 400; i++) begin
            send(byte_alu_pkg::alu_op_t'($urandom_range(5, 0)), 8'($urandom), 7'($urandom),
                1'($urandom));
        end
        $display("test random done");
        issued <= 1'b0;
        op <= byte_alu_pkg::OP_NONE;
        repeat (3) @(posedge clk_sys);
        end_of_test();
    end
endmodule
`default_nettype wire
